// [rtl/reservation_release_cmd.sv]
// Reservation release command interpreter for one namespace.
// Assumes a memory reader that returns the 8-byte key and a completion queue writer.
// What this block does
// - Executes one command that either releases or clears the namespace reservation.
// - Takes its parameters from doubleword 10 plus a release structure fetched from host memory.
// - With page pointers the buffer address comes from pointer entries 1 and 2.
// - With scatter gather lists the buffer is described only by list entry 1.
// - The 128-bit data pointer locates the host buffer holding the release structure.
// - For release, bits 15:8 of doubleword 10 give the reservation kind, which must equal the held one.
// - A kind that differs from a held kind other than none completes with invalid field status.
// - A set key-skip bit at bit 3 fails the command with invalid field status.
// - With the key-skip bit clear the supplied key is checked before acting.
// - Bits 2:0 select release for 000b, clear for 001b, and other codes are reserved.
// - On finishing, a completion entry with the status is posted to the completion queue.
module reservation_release_cmd
  import resv_release_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_id,
  input wire logic [31:0] dword10,
  input wire logic [127:0] buffer_pointer,
  input wire logic [1:0] xfer_kind,
  input wire logic [63:0] host_key,
  input wire logic fetch_done,
  input wire logic [63:0] fetch_data,
  input wire logic cpl_ready,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic cmd_ready,
  output logic fetch_req,
  output logic [63:0] fetch_addr_1,
  output logic [63:0] fetch_addr_2,
  output logic fetch_sgl,
  output logic cpl_valid,
  output logic [15:0] cpl_id,
  output logic [7:0] cpl_status,
  output logic [7:0] held_kind_out,
  output logic [31:0] reg_rdata
);
  cmd_state_e state_reg, state_next;
  logic ready_reg, ready_next;
  logic [15:0] id_reg, id_next;
  logic [31:0] dw10_reg, dw10_next;
  logic [63:0] present_key_reg, present_key_next;
  logic [63:0] addr1_reg, addr1_next;
  logic [63:0] addr2_reg, addr2_next;
  logic sgl_reg, sgl_next;
  logic [63:0] req_host_reg, req_host_next;
  logic fetch_req_reg, fetch_req_next;
  logic cpl_valid_reg, cpl_valid_next;
  logic [7:0] cpl_status_reg, cpl_status_next;
  logic [7:0] held_kind_reg, held_kind_next;
  logic [63:0] holder_key_reg, holder_key_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] chk_status;
  logic chk_release;
  logic chk_clear;
  logic holder_match;
  logic take_cmd;
  logic check_turn;

  // The command's buffer is described by a scatter gather list
  function automatic logic is_sgl(input logic [1:0] kind);
    return kind == XFER_SGL;
  endfunction

  function automatic logic reg_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] offset);
    return strobe && (addr == offset);
  endfunction

  // Taking needs the registered ready, so nothing is taken in the first cycle after reset
  assign take_cmd = cmd_valid && ready_reg;
  assign check_turn = (state_reg == ST_CHECK);
  // Only the host that holds the reservation actually releases it
  assign holder_match = (req_host_reg == holder_key_reg);

  release_check u_check (
    .dword10(dw10_reg),
    .present_key(present_key_reg),
    .holder_key(holder_key_reg),
    .held_kind(held_kind_reg),
    .holder_match(holder_match),
    .status(chk_status),
    .do_release(chk_release),
    .do_clear(chk_clear)
  );

  // Command sequence: take, fetch the release structure, check, wait for the queue
  always_comb
  begin
    state_next = state_reg;
    dw10_next = dw10_reg;
    present_key_next = present_key_reg;
    req_host_next = req_host_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (take_cmd)
        begin
          dw10_next = dword10;
          req_host_next = host_key;
          state_next = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (fetch_done)
        begin
          present_key_next = fetch_data;
          state_next = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        state_next = ST_POST;
      end
      ST_POST:
      begin
        if (cpl_ready)
        begin
          state_next = ST_IDLE;
        end
      end
    endcase
    ready_next = (state_next == ST_IDLE) && ctrl_next[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
      dw10_reg <= REG_ADDR_RESET;
      present_key_reg <= KEY_RESET;
      req_host_reg <= KEY_RESET;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      dw10_reg <= dw10_next;
      present_key_reg <= present_key_next;
      req_host_reg <= req_host_next;
    end
  end

  // Fetch request and the buffer location latched with the command
  always_comb
  begin
    fetch_req_next = (state_reg == ST_FETCH);
    addr1_next = addr1_reg;
    addr2_next = addr2_reg;
    sgl_next = sgl_reg;
    if (take_cmd)
    begin
      addr1_next = buffer_pointer[63:0];
      addr2_next = buffer_pointer[127:64];
      sgl_next = is_sgl(xfer_kind);
      if (is_sgl(xfer_kind))
      begin
        addr2_next = 64'h0000000000000000;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_req_reg <= 1'b0;
      addr1_reg <= KEY_RESET;
      addr2_reg <= KEY_RESET;
      sgl_reg <= 1'b0;
    end
    else
    begin
      fetch_req_reg <= fetch_req_next;
      addr1_reg <= addr1_next;
      addr2_reg <= addr2_next;
      sgl_reg <= sgl_next;
    end
  end

  // Completion entry; it stands until the queue takes it
  always_comb
  begin
    id_next = id_reg;
    cpl_valid_next = cpl_valid_reg;
    cpl_status_next = cpl_status_reg;
    if (take_cmd)
    begin
      id_next = cmd_id;
    end
    if (check_turn)
    begin
      cpl_status_next = chk_status;
      cpl_valid_next = 1'b1;
    end
    else if (cpl_valid_reg && cpl_ready)
    begin
      cpl_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      id_reg <= CMD_ID_RESET;
      cpl_valid_reg <= 1'b0;
      cpl_status_reg <= STATUS_SUCCESS;
    end
    else
    begin
      id_reg <= id_next;
      cpl_valid_reg <= cpl_valid_next;
      cpl_status_reg <= cpl_status_next;
    end
  end

  // Held reservation; a register write in the same cycle as a completion wins
  always_comb
  begin
    held_kind_next = held_kind_reg;
    holder_key_next = holder_key_reg;
    if (check_turn && chk_clear)
    begin
      held_kind_next = KIND_NONE;
      holder_key_next = KEY_RESET;
    end
    else if (check_turn && chk_release)
    begin
      held_kind_next = KIND_NONE;
    end
    if (reg_hit(reg_write, reg_addr, OFF_STATUS))
    begin
      held_kind_next = reg_wdata[7:0];
    end
    if (reg_hit(reg_write, reg_addr, OFF_HOLDER_LO))
    begin
      holder_key_next[31:0] = reg_wdata;
    end
    if (reg_hit(reg_write, reg_addr, OFF_HOLDER_HI))
    begin
      holder_key_next[63:32] = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      held_kind_reg <= KIND_NONE;
      holder_key_reg <= KEY_RESET;
    end
    else
    begin
      held_kind_reg <= held_kind_next;
      holder_key_reg <= holder_key_next;
    end
  end

  // Register port: control word, and read data that stand for exactly one cycle
  always_comb
  begin
    ctrl_next = ctrl_reg;
    rdata_next = 32'h00000000;
    if (reg_hit(reg_write, reg_addr, OFF_CTRL))
    begin
      ctrl_next = reg_wdata;
    end
    if (reg_read)
    begin
      unique case (reg_addr)
        OFF_CTRL: rdata_next = ctrl_reg;
        OFF_STATUS: rdata_next = {21'h000000, state_reg, held_kind_reg};
        OFF_HOLDER_LO: rdata_next = holder_key_reg[31:0];
        OFF_HOLDER_HI: rdata_next = holder_key_reg[63:32];
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= CTRL_RESET;
      rdata_reg <= REG_ADDR_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign fetch_req = fetch_req_reg;
  assign fetch_addr_1 = addr1_reg;
  assign fetch_addr_2 = addr2_reg;
  assign fetch_sgl = sgl_reg;
  assign cpl_valid = cpl_valid_reg;
  assign cpl_id = id_reg;
  assign cpl_status = cpl_status_reg;
  assign held_kind_out = held_kind_reg;
  assign reg_rdata = rdata_reg;
endmodule // reservation_release_cmd

// [inc/resv_release_pkg.sv]
// Constants for the reservation release command interpreter.
// Assumes one core clock; queue transport and memory fetch sit outside.
package resv_release_pkg;
  localparam logic [2:0] ACT_RELEASE = 3'h0;
  localparam logic [2:0] ACT_CLEAR = 3'h1;
  localparam int ACT_LSB = 0;
  localparam int ACT_MSB = 2;
  localparam int SKIP_KEY_BIT = 3;
  localparam int KIND_LSB = 8;
  localparam int KIND_MSB = 15;
  localparam logic [7:0] KIND_NONE = 8'h00;
  localparam logic [63:0] KEY_RESET = 64'h0000000000000000;
  localparam logic [7:0] STATUS_SUCCESS = 8'h00;
  localparam logic [7:0] STATUS_INVALID_FIELD = 8'h02;
  localparam logic [7:0] STATUS_CONFLICT = 8'h83;
  localparam logic [1:0] XFER_PRP = 2'h0;
  localparam logic [1:0] XFER_SGL = 2'h1;
  localparam logic [15:0] CMD_ID_RESET = 16'h0000;
  localparam logic [31:0] REG_ADDR_RESET = 32'h00000000;
  // Register port offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_HOLDER_LO = 4'h8;
  localparam logic [3:0] OFF_HOLDER_HI = 4'hC;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_CHECK, ST_POST} cmd_state_e;
endpackage

// [rtl/release_check.sv]
// Validation of a release command against held reservation state.
// Assumes purely combinational use by the interpreter.
module release_check
  import resv_release_pkg::*;
(
  input wire logic [31:0] dword10,
  input wire logic [63:0] present_key,
  input wire logic [63:0] holder_key,
  input wire logic [7:0] held_kind,
  input wire logic holder_match,
  output logic [7:0] status,
  output logic do_release,
  output logic do_clear
);
  logic [2:0] release_action;
  logic skip_key_check;
  logic [7:0] resv_kind;

  always_comb
  begin
    release_action = dword10[ACT_MSB:ACT_LSB];
    skip_key_check = dword10[SKIP_KEY_BIT];
    resv_kind = dword10[KIND_MSB:KIND_LSB];
    status = STATUS_SUCCESS;
    do_release = 1'b0;
    do_clear = 1'b0;
    if (skip_key_check)
    begin
      status = STATUS_INVALID_FIELD;
    end
    else if (release_action != ACT_RELEASE && release_action != ACT_CLEAR)
    begin
      status = STATUS_INVALID_FIELD;
    end
    else if (present_key != holder_key)
    begin
      status = STATUS_CONFLICT;
    end
    else if (release_action == ACT_CLEAR)
    begin
      do_clear = 1'b1;
    end
    else if (held_kind != KIND_NONE && resv_kind != held_kind)
    begin
      status = STATUS_INVALID_FIELD;
    end
    else
    begin
      do_release = holder_match && held_kind != KIND_NONE;
    end
  end
endmodule // release_check

// [sim/resv_release_asserts.sv]
// Port assertions for the release command interpreter.
// Bound into reservation_release_cmd; sees only its ports.
module resv_release_asserts
  import resv_release_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [31:0] dword10,
  input wire logic [127:0] buffer_pointer,
  input wire logic fetch_done,
  input wire logic cpl_ready,
  input wire logic fetch_req,
  input wire logic [63:0] fetch_addr_1,
  input wire logic [63:0] fetch_addr_2,
  input wire logic fetch_sgl,
  input wire logic cpl_valid,
  input wire logic [7:0] cpl_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] word_reg;
  logic [127:0] ptr_reg;
  // Command fields as taken, for checks after the inputs move on
  always_ff @(posedge clk)
  begin
    if (cmd_valid && cmd_ready)
    begin
      word_reg <= dword10;
      ptr_reg <= buffer_pointer;
    end
  end
  fetch_delay_a: assert property (cmd_valid && cmd_ready |-> ##2 fetch_req)
    else $error("fetch request late");
  fetch_pulse_a: assert property (fetch_req |=> !fetch_req)
    else $error("fetch request too long");
  prp_addr_a: assert property (fetch_req && !fetch_sgl |-> {fetch_addr_2, fetch_addr_1} == ptr_reg)
    else $error("page pointer address wrong");
  sgl_addr_a: assert property (fetch_req && fetch_sgl |-> {fetch_addr_2, fetch_addr_1} == {64'h0, ptr_reg[63:0]})
    else $error("list address wrong");
  cpl_delay_a: assert property (fetch_done |-> ##2 cpl_valid)
    else $error("completion late");
  cpl_hold_a: assert property (cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_status))
    else $error("completion dropped");
  skip_key_a: assert property (cpl_valid && word_reg[SKIP_KEY_BIT] |-> cpl_status == STATUS_INVALID_FIELD)
    else $error("key skip bit accepted");
  reserved_act_a: assert property (cpl_valid && word_reg[2:1] != 2'h0 |-> cpl_status == STATUS_INVALID_FIELD)
    else $error("reserved action accepted");
endmodule // resv_release_asserts

bind reservation_release_cmd resv_release_asserts chk_u (
  .clk(clk),
  .resetn(resetn),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .dword10(dword10),
  .buffer_pointer(buffer_pointer),
  .fetch_done(fetch_done),
  .cpl_ready(cpl_ready),
  .fetch_req(fetch_req),
  .fetch_addr_1(fetch_addr_1),
  .fetch_addr_2(fetch_addr_2),
  .fetch_sgl(fetch_sgl),
  .cpl_valid(cpl_valid),
  .cpl_status(cpl_status)
);

// [sim/host_model.sv]
// Host side: serves the release structure fetch and drains completions.
// Assumes one fetch outstanding at a time.
module host_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetch_req,
  input wire logic [63:0] key,
  input wire logic [3:0] delay,
  input wire logic cpl_valid,
  output logic fetch_done,
  output logic [63:0] fetch_data,
  output logic cpl_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg <= 5'h00;
      fetch_done <= 1'b0;
      fetch_data <= 64'h0;
      cpl_ready <= 1'b0;
    end
    else
    begin
      fetch_done <= 1'b0;
      // Data toggles outside the done pulse
      fetch_data <= ~fetch_data;
      cpl_ready <= cpl_valid && !cpl_ready;
      if (fetch_req)
        cnt_reg <= {1'b0, delay} + 5'h01;
      else if (cnt_reg != 5'h00)
        cnt_reg <= cnt_reg - 5'h01;
      if (cnt_reg == 5'h01)
      begin
        fetch_done <= 1'b1;
        fetch_data <= key;
      end
    end
  end
endmodule // host_model

// [sim/testbench.sv]
// Self-checking bench for the release command interpreter.
// Assumes the host model and the bound checker.
module testbench
  import resv_release_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] HOLDER = 64'h0123456789ABCDEF;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_id = 16'h0000;
  logic [31:0] dword10 = 32'h0;
  logic [127:0] buffer_pointer = 128'h0;
  logic [1:0] xfer_kind = 2'h0;
  logic [63:0] host_key = HOLDER;
  logic [63:0] pkey = 64'h0;
  logic [3:0] delay = 4'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic cmd_ready, fetch_req, fetch_sgl, cpl_valid, fetch_done, cpl_ready;
  logic [63:0] fetch_addr_1, fetch_addr_2, fetch_data;
  logic [15:0] cpl_id;
  logic [7:0] cpl_status, held_kind_out;
  logic [31:0] reg_rdata;
  int errors = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  reservation_release_cmd dut_u (
    .clk(clk),
    .resetn(resetn),
    .cmd_valid(cmd_valid),
    .cmd_id(cmd_id),
    .dword10(dword10),
    .buffer_pointer(buffer_pointer),
    .xfer_kind(xfer_kind),
    .host_key(host_key),
    .fetch_done(fetch_done),
    .fetch_data(fetch_data),
    .cpl_ready(cpl_ready),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .cmd_ready(cmd_ready),
    .fetch_req(fetch_req),
    .fetch_addr_1(fetch_addr_1),
    .fetch_addr_2(fetch_addr_2),
    .fetch_sgl(fetch_sgl),
    .cpl_valid(cpl_valid),
    .cpl_id(cpl_id),
    .cpl_status(cpl_status),
    .held_kind_out(held_kind_out),
    .reg_rdata(reg_rdata)
  );
  host_model host_u (
    .clk(clk),
    .resetn(resetn),
    .fetch_req(fetch_req),
    .key(pkey),
    .delay(delay),
    .cpl_valid(cpl_valid),
    .fetch_done(fetch_done),
    .fetch_data(fetch_data),
    .cpl_ready(cpl_ready)
  );
  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input logic done_wait);
    int n = 0;
    while ((done_wait ? cpl_valid : cmd_ready) !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 100)
      begin
        errors++;
        test_done();
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check({32'h0, reg_rdata}, {32'h0, exp});
  endtask
  // Command id, transfer kind, buffer pointer and fetch delay change on every run
  task automatic run(input logic [31:0] d, input logic [63:0] k, input logic [7:0] st, input logic [7:0] kd);
    wait_for(1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    dword10 <= d;
    pkey <= k;
    cmd_id <= cmd_id + 16'h0001;
    delay <= delay + 4'h3;
    xfer_kind <= xfer_kind ^ 2'h1;
    buffer_pointer <= buffer_pointer + {64'h1000, 64'h2000};
    @(posedge clk);
    cmd_valid <= 1'b0;
    wait_for(1'b1);
    check({56'h0, cpl_status}, {56'h0, st});
    check({48'h0, cpl_id}, {48'h0, cmd_id});
    wait_for(1'b0);
    check({56'h0, held_kind_out}, {56'h0, kd});
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(OFF_CTRL, CTRL_RESET);
    rd(4'h2, 32'h0);
    wr(OFF_HOLDER_LO, HOLDER[31:0]);
    wr(OFF_HOLDER_HI, HOLDER[63:32]);
    wr(OFF_STATUS, 32'h3);
    rd(OFF_HOLDER_HI, HOLDER[63:32]);
    run(32'h0308, HOLDER, STATUS_INVALID_FIELD, 8'h03);
    for (int a = 2; a < 8; a++)
      run(32'h0300 | 32'(a), HOLDER, STATUS_INVALID_FIELD, 8'h03);
    run(32'h0300, ~HOLDER, STATUS_CONFLICT, 8'h03);
    run(32'h0500, HOLDER, STATUS_INVALID_FIELD, 8'h03);
    run(32'h0300, HOLDER, STATUS_SUCCESS, 8'h00);
    wr(OFF_STATUS, 32'h5);
    run(32'h0001, HOLDER, STATUS_SUCCESS, 8'h00);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_HOLDER_LO, 32'h0);
    wr(OFF_STATUS, 32'h3);
    run(32'h0300, 64'h0, STATUS_SUCCESS, 8'h03);
    test_done();
  end
endmodule // testbench
